/* File: rtl/ccs_alu.sv */
// Purpose: arithmetic on the main operand with flag results
// Assumes: divide by zero leaves both operand registers unchanged
// Notes: combinational only
`timescale 1ns/1ps
module ccs_alu
    import ccs_pkg::*;
(
    ccs_alu_if.alu bus
);
    logic [8:0] wide;
    logic [4:0] nib;
    logic [15:0] product;
    logic [7:0] a;
    logic [7:0] s;

    always_comb begin
        a = bus.main_operand;
        s = bus.source;
        wide = 9'h000;
        nib = 5'h00;
        product = 16'h0000;
        bus.main_result = a;
        bus.second_result = bus.second_operand;
        bus.writes_second = 1'b0;
        bus.carry_flag = 1'b0;
        bus.half_carry_flag = 1'b0;
        bus.arith_range_flag = 1'b0;
        case (bus.op)
            CCS_OP_ADD, CCS_OP_ADDC: begin
                wide = {1'b0, a} + {1'b0, s} + {8'h00, (bus.op == CCS_OP_ADDC) & bus.carry_in};
                nib = {1'b0, a[3:0]} + {1'b0, s[3:0]} + {4'h0, (bus.op == CCS_OP_ADDC) & bus.carry_in};
                bus.main_result = wide[7:0];
                bus.carry_flag = wide[8];
                bus.half_carry_flag = nib[4];
                bus.arith_range_flag = (a[7] == s[7]) && (wide[7] != a[7]);
            end
            CCS_OP_SUBB: begin
                wide = {1'b0, a} - {1'b0, s} - {8'h00, bus.carry_in};
                nib = {1'b0, a[3:0]} - {1'b0, s[3:0]} - {4'h0, bus.carry_in};
                bus.main_result = wide[7:0];
                bus.carry_flag = wide[8];
                bus.half_carry_flag = nib[4];
                bus.arith_range_flag = (a[7] != s[7]) && (wide[7] != a[7]);
            end
            CCS_OP_MUL: begin
                product = {8'h00, a} * {8'h00, bus.second_operand};
                bus.main_result = product[7:0];
                bus.second_result = product[15:8];
                bus.writes_second = 1'b1;
                bus.arith_range_flag = product > {8'h00, PRODUCT_LIMIT};
            end
            default: begin
                // divide: zero divisor only raises the range flag
                if (bus.second_operand == 8'h00) begin
                    bus.arith_range_flag = 1'b1;
                end else begin
                    bus.main_result = a / bus.second_operand;
                    bus.second_result = a % bus.second_operand;
                    bus.writes_second = 1'b1;
                end
            end
        endcase
    end
endmodule : ccs_alu

/* File: rtl/ccs_alu_if.sv */
// Purpose: carries operands and results between register file and arithmetic unit
// Assumes: purely combinational exchange
// Notes: none
`timescale 1ns/1ps
interface ccs_alu_if;
    import ccs_pkg::*;
    ccs_op_e op;
    logic [7:0] main_operand;
    logic [7:0] second_operand;
    logic [7:0] source;
    logic carry_in;
    logic [7:0] main_result;
    logic [7:0] second_result;
    logic writes_second;
    logic carry_flag;
    logic half_carry_flag;
    logic arith_range_flag;

    modport regs (output op, main_operand, second_operand, source, carry_in,
                  input main_result, second_result, writes_second, carry_flag, half_carry_flag, arith_range_flag);
    modport alu (input op, main_operand, second_operand, source, carry_in,
                 output main_result, second_result, writes_second, carry_flag, half_carry_flag, arith_range_flag);
endinterface : ccs_alu_if

/* File: rtl/ccs_pkg.sv */
// Purpose: constants and types for the core special register block
// Assumes: 8-bit special-function space, one system clock
// Notes: shared by the register file and its arithmetic unit
package ccs_pkg;
    localparam logic [7:0] ADDR_STACK_TOP = 8'h81;
    localparam logic [7:0] ADDR_PTR_LOW = 8'h82;
    localparam logic [7:0] ADDR_PTR_HIGH = 8'h83;
    localparam logic [7:0] ADDR_STATUS = 8'hd0;
    localparam logic [7:0] ADDR_MAIN_OPERAND = 8'he0;
    localparam logic [7:0] ADDR_SECOND_OPERAND = 8'hf0;
    localparam logic [7:0] RESET_STACK_TOP = 8'h07;
    localparam logic [7:0] RESET_ZERO = 8'h00;
    localparam logic [2:0] BIT_GROUP_LOW = 3'h0;
    localparam int POS_CARRY = 7;
    localparam int POS_HALF_CARRY = 6;
    localparam int POS_USER_ZERO = 5;
    localparam int POS_BANK_HIGH = 4;
    localparam int POS_BANK_LOW = 3;
    localparam int POS_RANGE = 2;
    localparam int POS_USER_ONE = 1;
    localparam int POS_PARITY = 0;
    localparam logic [7:0] PRODUCT_LIMIT = 8'hff;

    typedef enum logic [2:0] {
        CCS_OP_ADD,
        CCS_OP_ADDC,
        CCS_OP_SUBB,
        CCS_OP_MUL,
        CCS_OP_DIV
    } ccs_op_e;
endpackage : ccs_pkg

/* File: rtl/ccs_regs.sv */
// Purpose: special registers of the processor core with direct-address access
// Assumes: one access per cycle; push, pop and an operation may coincide; synchronous apart from the asynchronous reset
// Notes: software write beats a core update of the same register in one cycle
`timescale 1ns/1ps
module ccs_regs
    import ccs_pkg::*;
(
    input wire logic CLK,
    input wire logic NRST,
    input wire logic [7:0] SFR_ADDR,
    input wire logic SFR_WR,
    input wire logic SFR_RD,
    input wire logic SFR_BIT,
    input wire logic [2:0] SFR_BITPOS,
    input wire logic [7:0] SFR_WDATA,
    output logic [7:0] SFR_RDATA,
    output logic SFR_HIT,
    input wire logic PUSH,
    input wire logic POP,
    input wire logic OP_VALID,
    input wire ccs_op_e OP_CODE,
    input wire logic [7:0] OP_SOURCE,
    output logic [7:0] STACK_TOP,
    output logic [15:0] INDIRECT_POINTER,
    output logic [7:0] STATUS_WORD,
    output logic [1:0] BANK_SELECT,
    output logic [7:0] MAIN_OPERAND,
    output logic [7:0] SECOND_OPERAND
);
    typedef struct packed {
        logic [7:0] stack_top_pointer;
        logic [7:0] pointer_low_byte;
        logic [7:0] pointer_high_byte;
        logic [7:0] program_status_word;
        logic [7:0] main_operand_register;
        logic [7:0] secondary_operand_register;
        logic [7:0] rdata;
        logic hit;
    } ccs_state_s;

    ccs_state_s st;
    ccs_state_s next_st;
    ccs_alu_if alu_bus ();
    logic bit_ok;
    logic [7:0] cur;
    logic [7:0] wval;
    logic known;

    ccs_alu u_alu (
        .bus(alu_bus)
    );

    assign alu_bus.op = OP_CODE;
    assign alu_bus.main_operand = st.main_operand_register;
    assign alu_bus.second_operand = st.secondary_operand_register;
    assign alu_bus.source = OP_SOURCE;
    assign alu_bus.carry_in = st.program_status_word[POS_CARRY];

    // bit access only on the 0/8 column
    assign bit_ok = SFR_ADDR[2:0] == BIT_GROUP_LOW;

    always_comb begin
        next_st = st;
        cur = 8'h00;
        known = 1'b1;
        if (SFR_ADDR == ADDR_STACK_TOP) begin
            cur = st.stack_top_pointer;
        end else if (SFR_ADDR == ADDR_PTR_LOW) begin
            cur = st.pointer_low_byte;
        end else if (SFR_ADDR == ADDR_PTR_HIGH) begin
            cur = st.pointer_high_byte;
        end else if (SFR_ADDR == ADDR_STATUS) begin
            cur = st.program_status_word;
        end else if (SFR_ADDR == ADDR_MAIN_OPERAND) begin
            cur = st.main_operand_register;
        end else if (SFR_ADDR == ADDR_SECOND_OPERAND) begin
            cur = st.secondary_operand_register;
        end else begin
            known = 1'b0;
        end
        // bit write merges one bit into the current byte
        wval = SFR_WDATA;
        if (SFR_BIT) begin
            wval = cur;
            wval[SFR_BITPOS] = SFR_WDATA[0];
        end

        // core actions first, software write may then override
        if (PUSH) begin
            next_st.stack_top_pointer = st.stack_top_pointer + 8'h01;
        end else if (POP) begin
            next_st.stack_top_pointer = st.stack_top_pointer - 8'h01;
        end
        if (OP_VALID) begin
            next_st.main_operand_register = alu_bus.main_result;
            if (alu_bus.writes_second) begin
                next_st.secondary_operand_register = alu_bus.second_result;
            end
            // user flags and bank select are left alone
            next_st.program_status_word[POS_CARRY] = alu_bus.carry_flag;
            next_st.program_status_word[POS_HALF_CARRY] = alu_bus.half_carry_flag;
            next_st.program_status_word[POS_RANGE] = alu_bus.arith_range_flag;
        end

        // a bit access to a byte-only address is dropped
        if (SFR_WR && known && (!SFR_BIT || bit_ok)) begin
            if (SFR_ADDR == ADDR_STACK_TOP) begin
                next_st.stack_top_pointer = wval;
            end else if (SFR_ADDR == ADDR_PTR_LOW) begin
                next_st.pointer_low_byte = wval;
            end else if (SFR_ADDR == ADDR_PTR_HIGH) begin
                next_st.pointer_high_byte = wval;
            end else if (SFR_ADDR == ADDR_STATUS) begin
                next_st.program_status_word[7:1] = wval[7:1];
            end else if (SFR_ADDR == ADDR_MAIN_OPERAND) begin
                next_st.main_operand_register = wval;
            end else begin
                next_st.secondary_operand_register = wval;
            end
        end

        // parity follows the operand value it will sit beside
        next_st.program_status_word[POS_PARITY] = ^next_st.main_operand_register;

        next_st.rdata = 8'h00;
        next_st.hit = 1'b0;
        if (SFR_RD && known && (!SFR_BIT || bit_ok)) begin
            next_st.hit = 1'b1;
            if (SFR_BIT) begin
                next_st.rdata = {7'h00, cur[SFR_BITPOS]};
            end else begin
                next_st.rdata = cur;
            end
        end
    end

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            st.stack_top_pointer <= RESET_STACK_TOP;
            st.pointer_low_byte <= RESET_ZERO;
            st.pointer_high_byte <= RESET_ZERO;
            st.program_status_word <= RESET_ZERO;
            st.main_operand_register <= RESET_ZERO;
            st.secondary_operand_register <= RESET_ZERO;
            st.rdata <= RESET_ZERO;
            st.hit <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    assign SFR_RDATA = st.rdata;
    assign SFR_HIT = st.hit;
    assign STACK_TOP = st.stack_top_pointer;
    assign INDIRECT_POINTER = {st.pointer_high_byte, st.pointer_low_byte};
    assign STATUS_WORD = st.program_status_word;
    assign BANK_SELECT = st.program_status_word[POS_BANK_HIGH:POS_BANK_LOW];
    assign MAIN_OPERAND = st.main_operand_register;
    assign SECOND_OPERAND = st.secondary_operand_register;
endmodule : ccs_regs

/* File: test/ccs_regs_assertions.sv */
// Purpose: port-level checks of the core special register block
// Assumes: one clock, reset active low
// Notes: sees only top-level ports
`timescale 1ns/1ps
module ccs_regs_assertions
    import ccs_pkg::*;
(
    input wire logic CLK,
    input wire logic NRST,
    input wire logic [7:0] SFR_ADDR,
    input wire logic SFR_WR,
    input wire logic SFR_RD,
    input wire logic SFR_BIT,
    input wire logic [7:0] SFR_WDATA,
    input wire logic [7:0] SFR_RDATA,
    input wire logic SFR_HIT,
    input wire logic PUSH,
    input wire logic [7:0] STACK_TOP,
    input wire logic [15:0] INDIRECT_POINTER,
    input wire logic [7:0] STATUS_WORD,
    input wire logic [1:0] BANK_SELECT,
    input wire logic [7:0] MAIN_OPERAND,
    input wire logic [7:0] SECOND_OPERAND
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!NRST);
    sequence s_main_read;
        SFR_RD && !SFR_BIT && SFR_ADDR == ADDR_MAIN_OPERAND;
    endsequence
    sequence s_main_answer;
        SFR_HIT && SFR_RDATA == $past(MAIN_OPERAND);
    endsequence
    a_parity_tracks: assert property (STATUS_WORD[0] == ^MAIN_OPERAND) else $error("parity wrong");
    a_ptr_low_write: assert property (SFR_WR && !SFR_BIT && SFR_ADDR == ADDR_PTR_LOW
        |=> INDIRECT_POINTER[7:0] == $past(SFR_WDATA)) else $error("low byte wrong");
    a_ptr_high_write: assert property (SFR_WR && !SFR_BIT && SFR_ADDR == ADDR_PTR_HIGH
        |=> INDIRECT_POINTER[15:8] == $past(SFR_WDATA)) else $error("high byte wrong");
    a_push_steps_up: assert property (PUSH && !(SFR_WR && SFR_ADDR == ADDR_STACK_TOP)
        |=> STACK_TOP == $past(STACK_TOP) + 8'h01) else $error("push step wrong");
    a_bank_follows: assert property (BANK_SELECT == STATUS_WORD[4:3]) else $error("bank wrong");
    a_user_flags_kept: assert property (!(SFR_WR && SFR_ADDR == ADDR_STATUS)
        |=> $stable(STATUS_WORD[5]) && $stable(STATUS_WORD[1])) else $error("user flag moved");
    a_main_read: assert property (s_main_read |=> s_main_answer) else $error("read wrong");
    a_bit_refused: assert property (SFR_RD && SFR_BIT && SFR_ADDR[2:0] != 3'h0
        |=> !SFR_HIT && SFR_RDATA == 8'h00) else $error("bit read not refused");
    a_reset_values: assert property ($rose(NRST) |-> STACK_TOP == RESET_STACK_TOP && STATUS_WORD == 8'h00
        && INDIRECT_POINTER == 16'h0000 && MAIN_OPERAND == 8'h00 && SECOND_OPERAND == 8'h00)
        else $error("reset value wrong");
endmodule : ccs_regs_assertions

bind ccs_regs ccs_regs_assertions u_chk (.CLK(CLK), .NRST(NRST), .SFR_ADDR(SFR_ADDR), .SFR_WR(SFR_WR),
    .SFR_RD(SFR_RD), .SFR_BIT(SFR_BIT), .SFR_WDATA(SFR_WDATA), .SFR_RDATA(SFR_RDATA), .SFR_HIT(SFR_HIT),
    .PUSH(PUSH), .STACK_TOP(STACK_TOP), .INDIRECT_POINTER(INDIRECT_POINTER), .STATUS_WORD(STATUS_WORD),
    .BANK_SELECT(BANK_SELECT), .MAIN_OPERAND(MAIN_OPERAND), .SECOND_OPERAND(SECOND_OPERAND));

/* File: test/ccs_regs_tb.sv */
// Purpose: self-checking bench for the core special register block
// Assumes: inputs change on the falling edge
// Notes: expected flags come from a bench reference function
`timescale 1ns/1ps
module ccs_regs_tb;
    import ccs_pkg::*;
    logic CLK = 0, NRST = 0, SFR_WR = 0, SFR_RD = 0, SFR_BIT = 0, PUSH = 0, POP = 0, OP_VALID = 0, SFR_HIT;
    logic [7:0] SFR_ADDR = 8'h80, SFR_WDATA = 8'h00, OP_SOURCE = 8'h00, SFR_RDATA, STACK_TOP, STATUS_WORD;
    logic [7:0] MAIN_OPERAND, SECOND_OPERAND, a, b, s, p;
    logic [7:0] spx = 8'h07;
    logic [2:0] SFR_BITPOS = 3'h0;
    logic [1:0] BANK_SELECT;
    logic [15:0] INDIRECT_POINTER;
    logic [23:0] e;
    ccs_op_e OP_CODE = CCS_OP_ADD;
    int num_errors = 0, samples_checked = 0, cycles = 0, seed = 32'h31e3;
    localparam logic [7:0] ADDRS [6] = '{8'h81, 8'h82, 8'h83, 8'hd0, 8'he0, 8'hf0};
    localparam logic [7:0] RSTV [6] = '{8'h07, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    ccs_regs DUT (.CLK(CLK), .NRST(NRST), .SFR_ADDR(SFR_ADDR), .SFR_WR(SFR_WR), .SFR_RD(SFR_RD),
        .SFR_BIT(SFR_BIT), .SFR_BITPOS(SFR_BITPOS), .SFR_WDATA(SFR_WDATA), .SFR_RDATA(SFR_RDATA),
        .SFR_HIT(SFR_HIT), .PUSH(PUSH), .POP(POP), .OP_VALID(OP_VALID), .OP_CODE(OP_CODE),
        .OP_SOURCE(OP_SOURCE), .STACK_TOP(STACK_TOP), .INDIRECT_POINTER(INDIRECT_POINTER),
        .STATUS_WORD(STATUS_WORD), .BANK_SELECT(BANK_SELECT), .MAIN_OPERAND(MAIN_OPERAND),
        .SECOND_OPERAND(SECOND_OPERAND));
    always #4 CLK = ~CLK;
    task automatic end_of_test;
        $display("checked %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : end_of_test
    always @(posedge CLK) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            end_of_test();
        end
    end
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("FAIL at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // one bus cycle; read data is settled at the closing falling edge
    task automatic acc(input logic w, r, bt, input logic [7:0] ad, input logic [2:0] pos, input logic [7:0] d);
        @(negedge CLK);
        {SFR_WR, SFR_RD, SFR_BIT, SFR_ADDR, SFR_BITPOS, SFR_WDATA} = {w, r, bt, ad, pos, d};
        @(negedge CLK);
        {SFR_WR, SFR_RD} = 2'b00;
    endtask : acc
    task automatic core(input logic pu, po, v, input ccs_op_e c, input logic [7:0] src);
        @(negedge CLK);
        {PUSH, POP, OP_VALID, OP_SOURCE} = {pu, po, v, src};
        OP_CODE = c;
        @(negedge CLK);
        {PUSH, POP, OP_VALID} = 3'b000;
    endtask : core
    // returns {main, second, status} after the operation
    function automatic logic [23:0] ref_op(input ccs_op_e op, input logic [7:0] a, b, s, p);
        logic [8:0] r;
        logic [4:0] h;
        logic [15:0] m;
        logic c;
        logic [7:0] q, rm, st;
        c = (op == CCS_OP_ADD) ? 1'b0 : p[7];
        {q, rm, st} = {a, b, p};
        case (op)
            CCS_OP_MUL: begin
                m = a * b;
                {rm, q} = m;
                st[7:6] = 2'b00;
                st[2] = |m[15:8];
            end
            CCS_OP_DIV: begin
                st[7:6] = 2'b00;
                st[2] = (b == 8'h00);
                if (b != 8'h00) {q, rm} = {a / b, a % b};
            end
            CCS_OP_SUBB: begin
                r = {1'b0, a} - s - c;
                h = {1'b0, a[3:0]} - s[3:0] - c;
                q = r[7:0];
                {st[7], st[6], st[2]} = {r[8], h[4], (a[7] != s[7]) && (q[7] != a[7])};
            end
            default: begin
                r = a + s + c;
                h = a[3:0] + s[3:0] + c;
                q = r[7:0];
                {st[7], st[6], st[2]} = {r[8], h[4], (a[7] == s[7]) && (q[7] != a[7])};
            end
        endcase
        st[0] = ^q;
        return {q, rm, st};
    endfunction : ref_op
    initial begin
        repeat (16) @(negedge CLK);
        NRST = 1;
        for (int i = 0; i < 6; i++) begin
            acc(0, 1, 0, ADDRS[i], 3'h0, 8'h00);
            check({SFR_HIT, SFR_RDATA}, {1'b1, RSTV[i]});
        end
        core(1, 0, 0, CCS_OP_ADD, 8'h00);
        check(STACK_TOP, 8'h08);
        acc(0, 1, 0, 8'h84, 3'h0, 8'h00);
        check({SFR_HIT, SFR_RDATA}, 9'h000);
        acc(0, 1, 1, 8'h81, 3'h0, 8'h00);
        check({SFR_HIT, SFR_RDATA}, 9'h000);
        acc(1, 0, 1, 8'he0, 3'h5, 8'h01);
        check({MAIN_OPERAND, STATUS_WORD[0]}, 9'h041);
        acc(1, 0, 0, 8'h82, 3'h0, 8'h3c);
        acc(1, 0, 0, 8'h83, 3'h0, 8'hc5);
        check(INDIRECT_POINTER, 16'hc53c);
        acc(0, 1, 1, 8'he0, 3'h5, 8'h00);
        check({SFR_HIT, SFR_RDATA}, 9'h101);
        // user flag set by bit write, parity bit write must be ignored
        acc(1, 0, 1, 8'hd0, 3'h1, 8'h01);
        acc(1, 0, 1, 8'hd0, 3'h0, 8'h00);
        check(STATUS_WORD, 8'h03);
        core(0, 1, 0, CCS_OP_ADD, 8'h00);
        check(STACK_TOP, 8'h07);
        for (int i = 0; i < 300; i++) begin
            {a, b, s, p} = $random(seed);
            // corners: signed overflow, large product, divide by zero
            if (i < 3) {a, b, s} = {8'h7f, i == 1 ? 8'hff : 8'h00, 8'h01};
            OP_CODE = ccs_op_e'(i < 3 ? i * 2 + (i == 1) : {1'b0, 2'($unsigned($random(seed)))} + (i % 2));
            acc(1, 0, 0, 8'he0, 3'h0, a);
            acc(1, 0, 0, 8'hf0, 3'h0, i == 1 ? a : b);
            acc(1, 0, 0, 8'hd0, 3'h0, p);
            check({STATUS_WORD, BANK_SELECT}, {p[7:1], ^a, p[4:3]});
            e = ref_op(OP_CODE, a, i == 1 ? a : b, s, {p[7:1], ^a});
            core(i % 7 == 0, i % 5 == 0, 1, OP_CODE, s);
            check({MAIN_OPERAND, SECOND_OPERAND, STATUS_WORD}, e);
            // push wins over pop in the same cycle
            spx = spx + ((i % 7 == 0) ? 8'h01 : (i % 5 == 0) ? 8'hff : 8'h00);
            check(STACK_TOP, spx);
        end
        end_of_test();
    end
endmodule : ccs_regs_tb
